// *** design/adcpsc_clkdiv.sv ***
/*
  Converter clock divider: half period of (div + 1) pclk cycles.
  Assumes div is static while enabled; a change takes effect within the current half period.
*/
module adcpsc_clkdiv #(
  parameter int DIV_W = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic enable,
  input wire logic [DIV_W-1:0] div,
  output logic half_tick,
  output logic clk_q
);
  logic [DIV_W-1:0] cnt_q;
  logic tick;

  // Compare not equal-only, so a smaller div written mid-count cannot stall a full wrap
  assign tick = enable && (cnt_q >= div);
  assign half_tick = tick;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= '0;
    end else if (!enable || tick) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  // Clock parks low while powered down
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_q <= 1'b0;
    end else if (!enable) begin
      clk_q <= 1'b0;
    end else if (tick) begin
      clk_q <= ~clk_q;
    end
  end
endmodule

// *** design/adcpsc_pipe.sv ***
/*
  Conversion latency line: one entry per converter half period.
  Assumes shift_en is the converter half-period tick and in_valid coincides with it.
*/
module adcpsc_pipe #(
  parameter int WIDTH = 12,
  parameter int STAGES = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic shift_en,
  input wire logic flush,
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  output logic [WIDTH-1:0] out_data
);
  logic [STAGES-1:0] vld_q;
  logic [WIDTH-1:0] dat_q [STAGES];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vld_q[0] <= 1'b0;
      dat_q[0] <= '0;
    end else if (flush) begin
      vld_q[0] <= 1'b0;
    end else if (shift_en) begin
      vld_q[0] <= in_valid;
      dat_q[0] <= in_data;
    end
  end

  for (genvar i = 1; i < STAGES; i++) begin : g_stage
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        vld_q[i] <= 1'b0;
        dat_q[i] <= '0;
      end else if (flush) begin
        vld_q[i] <= 1'b0;
      end else if (shift_en) begin
        vld_q[i] <= vld_q[i-1];
        dat_q[i] <= dat_q[i-1];
      end
    end
  end

  // Leaves the last stage STAGES half periods after entry
  assign out_valid = shift_en && vld_q[STAGES-1] && !flush;
  assign out_data = dat_q[STAGES-1];
endmodule

// *** design/adcpsc_pkg.sv ***
/*
  Types shared by the converter control block.
  Assumes nothing of its surroundings.
*/
package adcpsc_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_DELAY, ST_SAMPLE, ST_GAP} adcpsc_state_e;
  typedef logic [11:0] adcpsc_sample_t;
endpackage

// *** design/adcpsc_regs.svh ***
/*
  Register offsets, field positions, reset values and timing counts of the
  converter power and sequencing control block.
  Assumes a 32-bit APB slave with byte addresses, one aligned word per register.
*/
`ifndef ADCPSC_REGS_SVH
`define ADCPSC_REGS_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define ADCPSC_CTRL_OFS 8'h00
`define ADCPSC_POWER_OFS 8'h04
`define ADCPSC_CHSEL_OFS 8'h08
`define ADCPSC_START_OFS 8'h0c
`define ADCPSC_RES_A_OFS 8'h10
`define ADCPSC_RES_B_OFS 8'h14
`define ADCPSC_STATUS_OFS 8'h18
`define ADCPSC_INT_EN_OFS 8'h1c
`define ADCPSC_INT_CLR_OFS 8'h20

// ****************************************************************
// Field positions
// ****************************************************************
`define ADCPSC_CTRL_MODE_BIT 0
`define ADCPSC_CTRL_CONT_BIT 1
`define ADCPSC_CTRL_EM_EN_BIT 2
`define ADCPSC_CTRL_EXT_EN_BIT 3
`define ADCPSC_CTRL_DIV_LSB 4
`define ADCPSC_CTRL_ACQ_LSB 8
`define ADCPSC_POWER_REF_BIT 5
`define ADCPSC_POWER_BG_BIT 6
`define ADCPSC_POWER_CONV_BIT 7
`define ADCPSC_START_SW_BIT 0
`define ADCPSC_ST_DONE_A_BIT 0
`define ADCPSC_ST_DONE_B_BIT 1
`define ADCPSC_ST_IGNORED_BIT 2
`define ADCPSC_ST_BUSY_BIT 8
`define ADCPSC_ST_SETTLED_BIT 9

// ****************************************************************
// Reset values
// ****************************************************************
`define ADCPSC_CTRL_RST 16'h0040
`define ADCPSC_POWER_RST 3'h0
`define ADCPSC_CHSEL_RST 4'h0
`define ADCPSC_INT_EN_RST 3'h0

// ****************************************************************
// Timing, in converter half periods where named HALF, in ns where named NS; ADCPSC_FLAG_DELAY in pclk cycles
// ****************************************************************
`define ADCPSC_PCLK_PERIOD_NS 4
`define ADCPSC_PWD_SETTLE_NS 20000
`define ADCPSC_START_DELAY_HALF 5
`define ADCPSC_SEQ_GAP_HALF 2
`define ADCPSC_SIM_GAP_HALF 4
`define ADCPSC_LAT_A_HALF 8
`define ADCPSC_LAT_B_HALF 10
`define ADCPSC_FLAG_DELAY 2

`endif

// *** design/adcpsc_top.sv ***
/*
  Power-up and conversion sequencing control of a 16-input 12-bit pipelined
  converter, reached over APB.
  Assumes the analog core presents its digitised sample on core_data_a/b and
  holds it stable while sample_hold is high; pins are asynchronous to pclk.
*/
// The implementer's own choices: the address map and the APB register port.
`include "adcpsc_regs.svh"

module adcpsc_top
  import adcpsc_pkg::*;
#(
  parameter int PWD_SETTLE_CYCLES =
    (`ADCPSC_PWD_SETTLE_NS + `ADCPSC_PCLK_PERIOD_NS - 1) / `ADCPSC_PCLK_PERIOD_NS
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [1:0] event_trigger,
  input wire logic external_conversion_start,
  input wire logic [11:0] core_data_a,
  input wire logic [11:0] core_data_b,
  output logic converter_clock,
  output logic sample_hold,
  output logic [3:0] channel_a_sel,
  output logic [3:0] channel_b_sel,
  output logic bandgap_power_on,
  output logic reference_power_on,
  output logic converter_power_on,
  output logic irq
);
  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic [15:0] ctrl_q;
  logic [3:0] chsel_q, acq;
  logic [2:0] int_en_q, status_q, status_set, status_clr;
  adcpsc_sample_t result_a_q, result_b_q, res_a_dat, res_b_dat;
  adcpsc_sample_t core_a_s1_q, core_a_s2_q, core_b_s1_q, core_b_s2_q;
  logic sw_start_q, ready_q, mapped, wr_en, setup, ext_s1_q, ext_s2_q, ext_s3_q;
  logic [31:0] rdata_d;
  logic [12:0] settle_q;
  logic settled, mode_sim, cont, any_trig, start_req, half_tick, capture, res_a_vld, res_b_vld;
  adcpsc_state_e state_q;
  logic [5:0] cnt_q, sh_last, gap_last;
  logic [`ADCPSC_FLAG_DELAY-1:0] done_a_dly_q, done_b_dly_q;

  assign mode_sim = ctrl_q[`ADCPSC_CTRL_MODE_BIT];
  assign cont = ctrl_q[`ADCPSC_CTRL_CONT_BIT];
  assign acq = ctrl_q[`ADCPSC_CTRL_ACQ_LSB +: 4];

  // ****************************************************************
  // APB slave
  // ****************************************************************
  // One wait state: data and error are registered with pready
  assign setup = psel && penable && !ready_q;
  assign wr_en = psel && penable && ready_q && pwrite && mapped;

  always_comb begin
    mapped = 1'b1;
    rdata_d = 32'h00000000;
    unique case (paddr)
      `ADCPSC_CTRL_OFS: rdata_d[15:0] = ctrl_q;
      `ADCPSC_POWER_OFS: begin
        rdata_d[`ADCPSC_POWER_REF_BIT] = reference_power_on;
        rdata_d[`ADCPSC_POWER_BG_BIT] = bandgap_power_on;
        rdata_d[`ADCPSC_POWER_CONV_BIT] = converter_power_on;
      end
      `ADCPSC_CHSEL_OFS: rdata_d[3:0] = chsel_q;
      `ADCPSC_START_OFS, `ADCPSC_INT_CLR_OFS: rdata_d = 32'h00000000;
      `ADCPSC_RES_A_OFS: rdata_d[11:0] = result_a_q;
      `ADCPSC_RES_B_OFS: rdata_d[11:0] = result_b_q;
      `ADCPSC_STATUS_OFS: begin
        rdata_d[2:0] = status_q;
        rdata_d[`ADCPSC_ST_BUSY_BIT] = (state_q != ST_IDLE);
        rdata_d[`ADCPSC_ST_SETTLED_BIT] = settled;
      end
      `ADCPSC_INT_EN_OFS: rdata_d[2:0] = int_en_q;
      default: mapped = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ready_q <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      ready_q <= setup;
      prdata <= (setup && !pwrite) ? rdata_d : 32'h00000000;
      pslverr <= setup && !mapped;
    end
  end
  assign pready = ready_q;

  // ****************************************************************
  // Control registers
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= `ADCPSC_CTRL_RST;
    end else if (wr_en && paddr == `ADCPSC_CTRL_OFS) begin
      ctrl_q <= pwdata[15:0];
    end
  end

  // Bits are independent, so one write may clear all three at once
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reference_power_on <= 1'b0;
      bandgap_power_on <= 1'b0;
      converter_power_on <= 1'b0;
    end else if (wr_en && paddr == `ADCPSC_POWER_OFS) begin
      reference_power_on <= pwdata[`ADCPSC_POWER_REF_BIT];
      bandgap_power_on <= pwdata[`ADCPSC_POWER_BG_BIT];
      converter_power_on <= pwdata[`ADCPSC_POWER_CONV_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chsel_q <= `ADCPSC_CHSEL_RST;
    end else if (wr_en && paddr == `ADCPSC_CHSEL_OFS) begin
      chsel_q <= pwdata[3:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw_start_q <= 1'b0;
    end else begin
      sw_start_q <= wr_en && paddr == `ADCPSC_START_OFS && pwdata[`ADCPSC_START_SW_BIT];
    end
  end

  // Simultaneous pairs are always n with n+8
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      channel_a_sel <= 4'h0;
      channel_b_sel <= 4'h0;
    end else if (mode_sim) begin
      channel_a_sel <= {1'b0, chsel_q[2:0]};
      channel_b_sel <= {1'b1, chsel_q[2:0]};
    end else begin
      channel_a_sel <= chsel_q;
      channel_b_sel <= 4'h0;
    end
  end

  // ****************************************************************
  // Pin synchronisers and power settle timer
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {ext_s3_q, ext_s2_q, ext_s1_q} <= 3'h0;
      {core_a_s2_q, core_a_s1_q} <= 24'h000000;
      {core_b_s2_q, core_b_s1_q} <= 24'h000000;
    end else begin
      {ext_s3_q, ext_s2_q, ext_s1_q} <= {ext_s2_q, ext_s1_q, external_conversion_start};
      {core_a_s2_q, core_a_s1_q} <= {core_a_s1_q, core_data_a};
      {core_b_s2_q, core_b_s1_q} <= {core_b_s1_q, core_data_b};
    end
  end

  // Status only; software owns the wait, starts are not blocked by it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      settle_q <= 13'h0000;
    end else if (!converter_power_on) begin
      settle_q <= 13'h0000;
    end else if (!settled) begin
      settle_q <= settle_q + 13'h0001;
    end
  end
  assign settled = (settle_q >= 13'(PWD_SETTLE_CYCLES));

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  assign any_trig = sw_start_q
    || (ctrl_q[`ADCPSC_CTRL_EM_EN_BIT] && |event_trigger)
    || (ctrl_q[`ADCPSC_CTRL_EXT_EN_BIT] && ext_s2_q && !ext_s3_q);
  assign start_req = any_trig && converter_power_on && state_q == ST_IDLE;
  assign sh_last = {1'b0, acq, 1'b1}; // 2*(1+acq) half periods
  assign gap_last = mode_sim ? 6'(`ADCPSC_SIM_GAP_HALF - 1) : 6'(`ADCPSC_SEQ_GAP_HALF - 1);
  assign capture = half_tick && state_q == ST_SAMPLE && cnt_q == sh_last;

  adcpsc_clkdiv #(.DIV_W(4)) u_clkdiv (
    .pclk(pclk), .presetn(presetn), .enable(converter_power_on),
    .div(ctrl_q[`ADCPSC_CTRL_DIV_LSB +: 4]), .half_tick(half_tick), .clk_q(converter_clock)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_IDLE;
      cnt_q <= 6'h00;
      sample_hold <= 1'b0;
    end else if (!converter_power_on) begin
      state_q <= ST_IDLE;
      cnt_q <= 6'h00;
      sample_hold <= 1'b0;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          cnt_q <= 6'h00;
          if (start_req) begin
            state_q <= ST_DELAY;
          end
        end
        ST_DELAY: begin
          if (half_tick) begin
            cnt_q <= cnt_q + 6'h01;
            if (cnt_q == 6'(`ADCPSC_START_DELAY_HALF - 1)) begin
              state_q <= ST_SAMPLE;
              sample_hold <= 1'b1;
              cnt_q <= 6'h00;
            end
          end
        end
        ST_SAMPLE: begin
          if (half_tick) begin
            cnt_q <= cnt_q + 6'h01;
            if (cnt_q == sh_last) begin
              sample_hold <= 1'b0;
              cnt_q <= 6'h00;
              state_q <= cont ? ST_GAP : ST_IDLE;
            end
          end
        end
        ST_GAP: begin
          if (!cont) begin
            state_q <= ST_IDLE;
          end else if (half_tick) begin
            cnt_q <= cnt_q + 6'h01;
            if (cnt_q == gap_last) begin
              state_q <= ST_SAMPLE;
              sample_hold <= 1'b1;
              cnt_q <= 6'h00;
            end
          end
        end
      endcase
    end
  end

  // ****************************************************************
  // Conversion pipeline and results
  // ****************************************************************
  adcpsc_pipe #(.WIDTH(12), .STAGES(`ADCPSC_LAT_A_HALF)) u_pipe_a (
    .pclk(pclk), .presetn(presetn), .shift_en(half_tick), .flush(!converter_power_on),
    .in_valid(capture), .in_data(core_a_s2_q), .out_valid(res_a_vld), .out_data(res_a_dat)
  );

  adcpsc_pipe #(.WIDTH(12), .STAGES(`ADCPSC_LAT_B_HALF)) u_pipe_b (
    .pclk(pclk), .presetn(presetn), .shift_en(half_tick), .flush(!converter_power_on),
    .in_valid(capture && mode_sim), .in_data(core_b_s2_q), .out_valid(res_b_vld),
    .out_data(res_b_dat)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result_a_q <= '0;
      result_b_q <= '0;
    end else begin
      if (res_a_vld) begin
        result_a_q <= res_a_dat;
      end
      if (res_b_vld) begin
        result_b_q <= res_b_dat;
      end
    end
  end

  // Flags trail the result write so software never reads a stale word
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_a_dly_q <= '0;
      done_b_dly_q <= '0;
    end else begin
      done_a_dly_q <= {done_a_dly_q[`ADCPSC_FLAG_DELAY-2:0], res_a_vld};
      done_b_dly_q <= {done_b_dly_q[`ADCPSC_FLAG_DELAY-2:0], res_b_vld};
    end
  end

  // ****************************************************************
  // Interrupts
  // ****************************************************************
  assign status_set[`ADCPSC_ST_DONE_A_BIT] = done_a_dly_q[`ADCPSC_FLAG_DELAY-1];
  assign status_set[`ADCPSC_ST_DONE_B_BIT] = done_b_dly_q[`ADCPSC_FLAG_DELAY-1];
  assign status_set[`ADCPSC_ST_IGNORED_BIT] = any_trig && !converter_power_on;
  assign status_clr = (wr_en && paddr == `ADCPSC_INT_CLR_OFS) ? pwdata[2:0] : 3'h0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_q <= 3'h0;
    end else begin
      status_q <= (status_q & ~status_clr) | status_set;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_en_q <= `ADCPSC_INT_EN_RST;
    end else if (wr_en && paddr == `ADCPSC_INT_EN_OFS) begin
      int_en_q <= pwdata[2:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status_q & int_en_q);
    end
  end
endmodule

// *** verif/adcpsc_core_model.sv ***
/*
  Analog core stand-in: presents digitised samples to the block.
  Assumes sample_hold from the block; the data only hold still while it is high.
*/
module adcpsc_core_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic sample_hold,
  output logic [11:0] core_data_a,
  output logic [11:0] core_data_b
);
  timeunit 1ns;
  timeprecision 1ps;

  // Moving every cycle outside the hold, so a capture off the fall shows
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_data_a <= 12'h5a3;
      core_data_b <= 12'ha5c;
    end else if (!sample_hold) begin
      core_data_a <= 12'($urandom);
      core_data_b <= ~core_data_a;
    end
  end
endmodule

// *** verif/adcpsc_monitor.sv ***
/*
  Port-level assertions of the converter control block.
  Assumes one pclk domain reset by presetn; bound to every adcpsc_top.
*/
`include "adcpsc_regs.svh"

module adcpsc_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic converter_clock,
  input wire logic sample_hold,
  input wire logic [3:0] channel_a_sel,
  input wire logic [3:0] channel_b_sel,
  input wire logic bandgap_power_on,
  input wire logic reference_power_on,
  input wire logic converter_power_on
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] pw_bits;
  logic pwr_wr;

  assign pw_bits = pwdata[7:5];
  assign pwr_wr = psel && penable && pready && pwrite && paddr == `ADCPSC_POWER_OFS;

  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  property p_one_wait;
    psel && penable && !pready |=> pready;
  endproperty
  a_one_wait: assert property (p_one_wait) else $error("pready late");
  property p_ready_pulse;
    pready |=> !pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("pready too long");
  property p_rdata_idle;
    !pready |-> prdata == 32'h0;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("prdata not zero");
  property p_power_write;
    pwr_wr |=> {converter_power_on, bandgap_power_on, reference_power_on} == $past(pw_bits);
  endproperty
  a_power_write: assert property (p_power_write) else $error("power bits wrong");
  property p_clk_off;
    !converter_power_on [*2] |-> !converter_clock;
  endproperty
  a_clk_off: assert property (p_clk_off) else $error("clock runs unpowered");
  property p_sh_gone;
    !converter_power_on |=> !sample_hold;
  endproperty
  a_sh_gone: assert property (p_sh_gone) else $error("sample while off");
  property p_sh_width;
    $rose(sample_hold) |-> (sample_hold || !converter_power_on) [*2];
  endproperty
  a_sh_width: assert property (p_sh_width) else $error("sample too short");
  property p_pair;
    channel_b_sel != 4'h0 |-> channel_b_sel == {1'b1, channel_a_sel[2:0]} && !channel_a_sel[3];
  endproperty
  a_pair: assert property (p_pair) else $error("bad channel pair");

  c_sample: cover property ($fell(sample_hold));
  c_pair: cover property (sample_hold && channel_b_sel != 4'h0);
  c_off: cover property ($fell(converter_power_on));
endmodule

bind adcpsc_top adcpsc_monitor u_monitor (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .converter_clock(converter_clock), .sample_hold(sample_hold),
  .channel_a_sel(channel_a_sel), .channel_b_sel(channel_b_sel),
  .bandgap_power_on(bandgap_power_on), .reference_power_on(reference_power_on),
  .converter_power_on(converter_power_on));

// *** verif/adcpsc_top_tb.sv ***
/*
  Self-checking bench of the converter control block with an APB master.
  Assumes the analog core model and the bound port monitor.
*/
`include "adcpsc_regs.svh"

module adcpsc_top_tb
  import adcpsc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SETTLE = 20;
  localparam logic [7:0] STAT = `ADCPSC_STATUS_OFS;
  localparam logic [7:0] CTRL = `ADCPSC_CTRL_OFS;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rv;
  logic pready, pslverr, ev, ext_start = 1'b0, cclk, sh, bg_on, ref_on, conv_on, irq;
  logic [1:0] em_trig = 2'h0;
  logic [3:0] ch_a, ch_b;
  logic [11:0] core_a, core_b;
  int num_errors = 0, checks_done = 0;
  adcpsc_sample_t q_a[$], q_b[$];

  adcpsc_top #(.PWD_SETTLE_CYCLES(SETTLE)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .event_trigger(em_trig),
    .external_conversion_start(ext_start), .core_data_a(core_a), .core_data_b(core_b),
    .converter_clock(cclk), .sample_hold(sh), .channel_a_sel(ch_a), .channel_b_sel(ch_b),
    .bandgap_power_on(bg_on), .reference_power_on(ref_on), .converter_power_on(conv_on),
    .irq(irq));
  adcpsc_core_model CORE (.pclk(pclk), .presetn(presetn), .sample_hold(sh),
    .core_data_a(core_a), .core_data_b(core_b));

  // Reference model: the value held at each falling edge of the hold pulse
  always @(negedge sh) begin
    q_a.push_back(core_a);
    q_b.push_back(core_b);
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wrap_up();
    $display("Checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic hang(input string what);
    num_errors++;
    $display("ERROR %s expected done seen timeout", what);
    wrap_up();
  endtask

  // ****
  // APB master: result left in rv and ev
  // ****
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rv = prdata;
    ev = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) hang("pready");
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask

  // Select 0 waits on the hold pulse, 1 on irq
  task automatic wait_on(input int sel, input logic lvl, output int n);
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while ((sel == 0 ? sh : irq) !== lvl && n < 3000);
    if (n >= 3000) hang("wait");
  endtask

  // ****
  // One conversion run: mode, continuous and source from the index
  // ****
  task automatic conv(input int i);
    int acq, h, ch, m, c, s, n;
    m = i / 3;
    c = i % 2;
    s = i % 3;
    acq = $urandom_range(0, 15);
    h = $urandom_range(2, 4);
    ch = $urandom_range(0, 15);
    q_a.delete();
    q_b.delete();
    wr(`ADCPSC_CHSEL_OFS, 32'(ch));
    wr(`ADCPSC_INT_CLR_OFS, 32'h7);
    wr(`ADCPSC_INT_EN_OFS, 32'h1);
    wr(CTRL, 32'(m + 2 * c + (s == 1 ? 4 : 0) + (s == 2 ? 8 : 0) + 16 * (h - 1) + 256 * acq));
    case (s)
      0: wr(`ADCPSC_START_OFS, 32'h1);
      1: begin
        em_trig <= 2'($urandom_range(1, 3));
        @(posedge pclk);
        em_trig <= 2'h0;
      end
      default: begin
        ext_start <= 1'b1;
        repeat (4) @(posedge pclk);
        ext_start <= 1'b0;
      end
    endcase
    wait_on(0, 1'b1, n);
    wait_on(0, 1'b0, n);
    chk("hold width", 32'(2 * (1 + acq) * h), 32'(n));
    chk("channel a", m ? 32'(ch % 8) : 32'(ch), 32'(ch_a));
    chk("channel b", m ? 32'(8 + ch % 8) : 32'h0, 32'(ch_b));
    if (c) begin
      wait_on(0, 1'b1, n);
      chk("hold gap", 32'((m ? 4 : 2) * h), 32'(n));
      wait_on(0, 1'b0, n);
      wr(CTRL, 32'(m + 16 * (h - 1) + 256 * acq));
    end else begin
      wait_on(1, 1'b1, n);
      chk("flag delay", 32'h1, 32'(n >= 8 * h + 1 && n <= 8 * h + 5));
    end
    n = 0;
    do begin
      rd(STAT);
      n++;
    end while (rv[`ADCPSC_ST_BUSY_BIT] !== 1'b0 && n < 100);
    if (n >= 100) hang("busy");
    repeat (12 * h) @(posedge pclk);
    rd(STAT);
    chk("done a", 32'h1, 32'(rv[`ADCPSC_ST_DONE_A_BIT]));
    rd(`ADCPSC_RES_A_OFS);
    chk("result a", 32'(q_a[$]), rv);
    if (m) begin
      rd(`ADCPSC_RES_B_OFS);
      chk("result b", 32'(q_b[$]), rv);
    end
    $display("Test conv %0d done", i);
  endtask

  initial begin
    forever #2 pclk = ~pclk;
  end

  initial begin
    int n;
    void'($urandom(12));
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(CTRL);
    chk("ctrl reset", 32'(`ADCPSC_CTRL_RST), rv);
    rd(`ADCPSC_POWER_OFS);
    chk("power reset", 32'(`ADCPSC_POWER_RST), rv);
    rd(`ADCPSC_INT_EN_OFS);
    chk("int_en reset", 32'(`ADCPSC_INT_EN_RST), rv);
    rd(8'h40);
    chk("unmapped", 32'h1, {rv[30:0], ev});
    $display("Test reset done");
    wr(`ADCPSC_INT_EN_OFS, 32'h4);
    wr(`ADCPSC_START_OFS, 32'h1);
    rd(STAT);
    chk("ignored flag", 32'h1, 32'(rv[`ADCPSC_ST_IGNORED_BIT]));
    chk("irq raised", 32'h1, 32'({sh, irq}));
    wr(`ADCPSC_INT_EN_OFS, 32'h0);
    repeat (2) @(posedge pclk);
    chk("irq masked", 32'h0, 32'(irq));
    wr(`ADCPSC_INT_EN_OFS, 32'h4);
    wr(`ADCPSC_INT_CLR_OFS, 32'h4);
    repeat (2) @(posedge pclk);
    chk("irq cleared", 32'h0, 32'(irq));
    $display("Test unpowered start done");
    wr(`ADCPSC_POWER_OFS, 32'h60);
    repeat (SETTLE) @(posedge pclk);
    chk("bandgap first", 32'h3, 32'({conv_on, bg_on, ref_on}));
    wr(`ADCPSC_POWER_OFS, 32'he0);
    rd(STAT);
    chk("not settled", 32'h0, 32'(rv[`ADCPSC_ST_SETTLED_BIT]));
    repeat (SETTLE) @(posedge pclk);
    rd(STAT);
    chk("settled", 32'h1, 32'(rv[`ADCPSC_ST_SETTLED_BIT]));
    $display("Test power up done");
    for (int i = 0; i < 6; i++) begin
      conv(i);
    end
    wr(CTRL, 32'h0f12);
    wr(`ADCPSC_START_OFS, 32'h1);
    wait_on(0, 1'b1, n);
    wr(`ADCPSC_POWER_OFS, 32'h0);
    repeat (3) @(posedge pclk);
    chk("aborted", 32'h0, 32'({sh, cclk, conv_on, bg_on, ref_on}));
    $display("Test power down done");
    wrap_up();
  end
endmodule
